// [shared/i2cs_pkg.sv]
/*
 * shared constants and types for the 10-bit address slave receiver and its master.
 * assumes a 40 MHz system clock on both ends.
 */
package i2cs_pkg;
	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int SCL_HZ = 100_000;
	localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
	// address matching
	localparam logic [4:0] HI_PREFIX = 5'h1E;
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	// link-to-system event kinds
	localparam logic [1:0] EV_START = 2'h0;
	localparam logic [1:0] EV_BYTE = 2'h1;
	localparam logic [1:0] EV_ACKED = 2'h2;
	localparam logic [1:0] EV_STOP = 2'h3;
	// master register map and command field
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam int OP_POS = 8;
	localparam logic [1:0] OP_START = 2'h1;
	localparam logic [1:0] OP_BYTE = 2'h2;
	localparam logic [1:0] OP_STOP = 2'h3;
	localparam int ST_BUSY = 0;
	localparam int ST_NACK = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {C_IDLE, C_HI, C_LO, C_DATA, C_OFF} i2cs_cst_type;
	typedef enum logic [2:0] {L_IDLE, L_BITS, L_WACK, L_ACK, L_WREL, L_SKIP} i2cs_lst_type;
	typedef enum logic [1:0] {HOLD_NONE, HOLD_ADDR, HOLD_CKP} i2cs_hold_type;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} i2cs_hst_type;
endpackage

// [shared/i2cs_bus_if.sv]
/*
 * open-drain scl/sda wire between the slave end and the master end.
 * assumes each end drives low only through its output enable.
 */
`timescale 1ns/10ps
interface i2cs_bus_if;
	logic scl_dev_o;
	logic scl_dev_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic scl;
	logic sda;

	// wired-and with pull-up
	assign scl = !((scl_dev_oe & !scl_dev_o) | (scl_host_oe & !scl_host_o));
	assign sda = !((sda_dev_oe & !sda_dev_o) | (sda_host_oe & !sda_host_o));

	modport dev (output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe, input scl, sda);
	modport host (output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe, input scl, sda);
endinterface

// [rtl/i2cs_host_end.sv]
/*
 * bus master end: writes start, bytes and stop on the wire, ordered over axi4-lite.
 * assumes the slave may stretch scl at any low phase.
 */
`timescale 1ns/10ps
module i2cs_host_end #(
	parameter int QTR = i2cs_pkg::QTR_CYC
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [3:0] s_axi_awaddr, // write byte address
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	output logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	input wire logic [3:0] s_axi_araddr, // read byte address
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	i2cs_bus_if.host bus // the wire
);
	localparam int TKW = $clog2(QTR);
	localparam int ST_BUSY_I = i2cs_pkg::ST_BUSY;
	localparam int ST_NACK_I = i2cs_pkg::ST_NACK;

	if (QTR < 2) begin : g_chk
		$error("QTR must be at least 2");
	end

	i2cs_pkg::i2cs_hst_type hst_r;
	logic [1:0] ph_r;
	logic [TKW-1:0] tk_r;
	logic [3:0] bit_r;
	logic [8:0] tx_r;
	logic nack_r, scl_oe_r, sda_oe_r;
	logic scl1_r, scl2_r, sda1_r, sda2_r;
	logic aw_r, w_r, bvalid_r, rvalid_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [1:0] bresp_r, rresp_r;
	logic [7:0] last_r;
	logic tick, need, adv, wr_do, wr_ok;

	assign bus.scl_host_o = 1'b0;
	assign bus.sda_host_o = 1'b0;
	assign bus.scl_host_oe = scl_oe_r;
	assign bus.sda_host_oe = sda_oe_r;

	// pin synchronisers
	always_ff @(posedge clk_i) begin
		scl1_r <= bus.scl;
		scl2_r <= scl1_r;
		sda1_r <= bus.sda;
		sda2_r <= sda1_r;
	end

	// quarter-bit pacing; released scl must be seen high before going on
	assign tick = tk_r == TKW'(QTR - 1);
	assign need = (hst_r == i2cs_pkg::H_START && ph_r == 2'h0) ||
		(hst_r != i2cs_pkg::H_START && ph_r == 2'h2);
	assign adv = tick && (!need || scl2_r);

	always_ff @(posedge clk_i) begin
		if (rst_i || hst_r == i2cs_pkg::H_IDLE || adv) begin
			tk_r <= '0;
		end else if (!tick) begin
			tk_r <= tk_r + 1'b1;
		end
	end

	// axi write channels, taken in either order
	assign s_axi_awready = !aw_r && !bvalid_r;
	assign s_axi_wready = !w_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign wr_do = aw_r && w_r && !bvalid_r;
	assign wr_ok = awaddr_r == i2cs_pkg::REG_CMD && hst_r == i2cs_pkg::H_IDLE;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= i2cs_pkg::RESP_OKAY;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_r <= 1'b1;
				wdata_r <= s_axi_wstrb[1] ? s_axi_wdata : 32'h0;
			end
			if (wr_do) begin
				aw_r <= 1'b0;
				w_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? i2cs_pkg::RESP_OKAY : i2cs_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// axi read channel
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= i2cs_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= i2cs_pkg::RESP_OKAY;
			rdata_r <= 32'h0;
			if (s_axi_araddr == i2cs_pkg::REG_STAT) begin
				rdata_r[ST_BUSY_I] <= hst_r != i2cs_pkg::H_IDLE;
				rdata_r[ST_NACK_I] <= nack_r;
			end else if (s_axi_araddr == i2cs_pkg::REG_CMD) begin
				rdata_r[7:0] <= last_r;
			end else begin
				rresp_r <= i2cs_pkg::RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// wire sequencer: start, nine-bit byte slot, stop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hst_r <= i2cs_pkg::H_IDLE;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			tx_r <= 9'h1FF;
			nack_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			last_r <= 8'h00;
		end else begin
			case (hst_r)
				i2cs_pkg::H_IDLE: begin
					ph_r <= 2'h0;
					bit_r <= 4'h0;
					if (wr_do && wr_ok) begin
						case (wdata_r[i2cs_pkg::OP_POS +: 2])
							i2cs_pkg::OP_START: begin
								hst_r <= i2cs_pkg::H_START;
								scl_oe_r <= 1'b0;
								sda_oe_r <= 1'b0;
							end
							i2cs_pkg::OP_BYTE: begin
								hst_r <= i2cs_pkg::H_BIT;
								tx_r <= {wdata_r[7:0], 1'b1};
								last_r <= wdata_r[7:0];
							end
							i2cs_pkg::OP_STOP: hst_r <= i2cs_pkg::H_STOP;
							default: hst_r <= i2cs_pkg::H_IDLE;
						endcase
					end
				end
				i2cs_pkg::H_START: if (adv) begin
					ph_r <= ph_r + 2'h1;
					if (ph_r == 2'h0) sda_oe_r <= 1'b1;
					if (ph_r == 2'h1) scl_oe_r <= 1'b1;
					if (ph_r == 2'h2) hst_r <= i2cs_pkg::H_IDLE;
				end
				i2cs_pkg::H_BIT: if (adv) begin
					ph_r <= ph_r + 2'h1;
					case (ph_r)
						2'h0: sda_oe_r <= !tx_r[8];
						2'h1: scl_oe_r <= 1'b0;
						2'h2: if (bit_r == 4'h8) nack_r <= sda2_r;
						default: begin
							scl_oe_r <= 1'b1;
							tx_r <= {tx_r[7:0], 1'b1};
							bit_r <= bit_r + 4'h1;
							if (bit_r == 4'h8) hst_r <= i2cs_pkg::H_IDLE;
						end
					endcase
				end
				i2cs_pkg::H_STOP: if (adv) begin
					ph_r <= ph_r + 2'h1;
					if (ph_r == 2'h0) sda_oe_r <= 1'b1;
					if (ph_r == 2'h1) scl_oe_r <= 1'b0;
					if (ph_r == 2'h2) begin
						sda_oe_r <= 1'b0;
						hst_r <= i2cs_pkg::H_IDLE;
					end
				end
				default: hst_r <= i2cs_pkg::H_IDLE;
			endcase
		end
	end
endmodule

// [rtl/i2cs_dev_end.sv]
/*
 * slave receive end: 10-bit address reception, data bytes and scl stretching.
 * wire logic runs on the link clock; software-facing flags run on clk_i.
 * assumes the link clock is several times faster than scl and that bus
 * events are spaced far more than four system clocks apart.
 */
`timescale 1ns/10ps
module i2cs_dev_end (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic link_clk_i, // link sampling clock
	i2cs_bus_if.dev bus, // the wire
	input wire logic stretch_enable_bit_i, // stretch after data bytes
	input wire logic address_hold_enable_i, // stretch before address ack
	input wire logic data_hold_enable_i, // stretch before data ack
	input wire logic start_irq_en_i, // irq on start
	input wire logic own_addr_wr_i, // pulse: load own address
	input wire logic [7:0] own_addr_i, // own address value
	input wire logic buf_rd_i, // pulse: buffer read
	input wire logic irq_clr_i, // pulse: clear irq flag
	input wire logic ckp_set_i, // pulse: set release bit
	output logic port_irq_flag_o, // irq flag
	output logic buffer_full_flag_o, // buffer holds unread byte
	output logic address_update_flag_o, // address needs reload
	output logic clock_release_bit_o, // scl release bit
	output logic start_seen_o, // start seen since stop
	output logic [7:0] rx_tx_buffer_o, // received byte
	output logic [7:0] own_address_o // own address register
);
	// ---- link domain ----
	i2cs_pkg::i2cs_lst_type lst_r;
	logic lr1_r, lrst_r;
	logic scl1_r, scl2_r, scl3_r, sda1_r, sda2_r, sda3_r;
	logic g1_r, g2_r, g3_r, ga1_r, ga2_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_register;
	logic ack_r, scl_oe_r, sda_oe_r;
	logic ev_tgl_r;
	logic go_tgl_r, go_ack_r; // driven on clk_i, read here only through flops
	logic [1:0] ev_kind_r;
	logic [7:0] ev_byte_r;
	logic l_start, l_stop, l_rise, l_fall, go_hit;

	assign bus.scl_dev_o = 1'b0;
	assign bus.sda_dev_o = 1'b0;
	assign bus.scl_dev_oe = scl_oe_r;
	assign bus.sda_dev_oe = sda_oe_r;

	// reset and pin synchronisers on the link clock
	always_ff @(posedge link_clk_i) begin
		lr1_r <= rst_i;
		lrst_r <= lr1_r;
		scl1_r <= bus.scl;
		scl2_r <= scl1_r;
		scl3_r <= scl2_r;
		sda1_r <= bus.sda;
		sda2_r <= sda1_r;
		sda3_r <= sda2_r;
		g1_r <= go_tgl_r;
		g2_r <= g1_r;
		g3_r <= g2_r;
		ga1_r <= go_ack_r;
		ga2_r <= ga1_r;
	end

	// wire conditions
	assign l_start = scl2_r && scl3_r && sda3_r && !sda2_r;
	assign l_stop = scl2_r && scl3_r && !sda3_r && sda2_r;
	assign l_rise = scl2_r && !scl3_r;
	assign l_fall = !scl2_r && scl3_r;
	assign go_hit = g2_r ^ g3_r;

	// bit engine; each step toward software raises an event toggle
	always_ff @(posedge link_clk_i) begin
		if (lrst_r) begin
			lst_r <= i2cs_pkg::L_IDLE;
			cnt_r <= 4'h0;
			shift_register <= 8'h00;
			ack_r <= 1'b0;
			ev_tgl_r <= 1'b0;
			ev_kind_r <= i2cs_pkg::EV_STOP;
			ev_byte_r <= 8'h00;
		end else if (l_start) begin
			lst_r <= i2cs_pkg::L_BITS;
			cnt_r <= 4'h0;
			ev_tgl_r <= !ev_tgl_r;
			ev_kind_r <= i2cs_pkg::EV_START;
		end else if (l_stop) begin
			lst_r <= i2cs_pkg::L_IDLE;
			ev_tgl_r <= !ev_tgl_r;
			ev_kind_r <= i2cs_pkg::EV_STOP;
		end else begin
			case (lst_r)
				i2cs_pkg::L_BITS: begin
					if (l_rise) begin
						shift_register <= {shift_register[6:0], sda2_r};
						cnt_r <= cnt_r + 4'h1;
					end
					if (l_fall && cnt_r == 4'h8) begin
						lst_r <= i2cs_pkg::L_WACK;
						ev_tgl_r <= !ev_tgl_r;
						ev_kind_r <= i2cs_pkg::EV_BYTE;
						ev_byte_r <= shift_register;
					end
				end
				i2cs_pkg::L_WACK: if (go_hit) begin
					ack_r <= ga2_r;
					lst_r <= i2cs_pkg::L_ACK;
				end
				i2cs_pkg::L_ACK: if (l_fall) begin
					lst_r <= ack_r ? i2cs_pkg::L_WREL : i2cs_pkg::L_SKIP;
					ev_tgl_r <= !ev_tgl_r;
					ev_kind_r <= i2cs_pkg::EV_ACKED;
				end
				i2cs_pkg::L_WREL: if (go_hit) begin
					lst_r <= i2cs_pkg::L_BITS;
					cnt_r <= 4'h0;
				end
				default: cnt_r <= 4'h0;
			endcase
		end
	end

	// pin drive; sda settles one link cycle before scl is let go
	always_ff @(posedge link_clk_i) begin
		if (lrst_r) begin
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else begin
			scl_oe_r <= lst_r == i2cs_pkg::L_WACK || lst_r == i2cs_pkg::L_WREL ||
				(lst_r == i2cs_pkg::L_ACK && ack_r && !sda_oe_r);
			sda_oe_r <= lst_r == i2cs_pkg::L_ACK && ack_r;
		end
	end

	// ---- system domain ----
	i2cs_pkg::i2cs_cst_type cst_r;
	i2cs_pkg::i2cs_hold_type hold_r;
	logic e1_r, e2_r, e3_r;
	logic pend_r;
	logic note_r, acked_r, was_addr_r;
	logic irq_r, bf_r, ua_r, ckp_r, ss_r;
	logic [7:0] buf_r, own_r;
	logic ev_hit, is_start, is_stop, is_byte, is_acked;
	logic m_hi, m_lo, ack_c, hold_en_c, go_ok, ckp_clr;

	// event toggle synchroniser; kind and byte are stable by then
	always_ff @(posedge clk_i) begin
		e1_r <= ev_tgl_r;
		e2_r <= e1_r;
		e3_r <= e2_r;
	end

	assign ev_hit = !rst_i && (e2_r ^ e3_r);
	assign is_start = ev_hit && ev_kind_r == i2cs_pkg::EV_START;
	assign is_stop = ev_hit && ev_kind_r == i2cs_pkg::EV_STOP;
	assign is_byte = ev_hit && ev_kind_r == i2cs_pkg::EV_BYTE;
	assign is_acked = ev_hit && ev_kind_r == i2cs_pkg::EV_ACKED;

	// address comparison against own address
	assign m_hi = ev_byte_r[7:3] == i2cs_pkg::HI_PREFIX && ev_byte_r[2:1] == own_r[2:1] &&
		!ev_byte_r[0];
	assign m_lo = ev_byte_r == own_r;

	always_comb begin
		case (cst_r)
			i2cs_pkg::C_HI: ack_c = m_hi;
			i2cs_pkg::C_LO: ack_c = m_lo;
			i2cs_pkg::C_DATA: ack_c = 1'b1;
			default: ack_c = 1'b0;
		endcase
	end

	assign hold_en_c = cst_r == i2cs_pkg::C_DATA ? data_hold_enable_i : address_hold_enable_i;
	assign ckp_clr = (is_byte && ack_c && hold_en_c) ||
		(is_acked && acked_r && !was_addr_r && stretch_enable_bit_i);
	assign go_ok = hold_r == i2cs_pkg::HOLD_NONE || (hold_r == i2cs_pkg::HOLD_CKP && ckp_r) ||
		(hold_r == i2cs_pkg::HOLD_ADDR && own_addr_wr_i);

	// addressing phase
	always_ff @(posedge clk_i) begin
		if (rst_i || is_stop) begin
			cst_r <= i2cs_pkg::C_IDLE;
		end else if (is_start) begin
			cst_r <= i2cs_pkg::C_HI;
		end else if (is_byte && cst_r == i2cs_pkg::C_HI) begin
			cst_r <= m_hi ? i2cs_pkg::C_LO : i2cs_pkg::C_OFF;
		end else if (is_byte && cst_r == i2cs_pkg::C_LO) begin
			cst_r <= m_lo ? i2cs_pkg::C_DATA : i2cs_pkg::C_OFF;
		end
	end

	// per-byte memory for the ack event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			note_r <= 1'b0;
			acked_r <= 1'b0;
			was_addr_r <= 1'b0;
		end else if (is_byte) begin
			note_r <= ack_c || cst_r == i2cs_pkg::C_LO;
			acked_r <= ack_c;
			was_addr_r <= cst_r != i2cs_pkg::C_DATA;
		end
	end

	// go handshake to the link: ack decision, then release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_r <= 1'b0;
			hold_r <= i2cs_pkg::HOLD_NONE;
			go_tgl_r <= 1'b0;
			go_ack_r <= 1'b0;
		end else if (is_start || is_stop) begin
			pend_r <= 1'b0;
		end else if (is_byte) begin
			pend_r <= 1'b1;
			go_ack_r <= ack_c;
			hold_r <= ack_c && hold_en_c ? i2cs_pkg::HOLD_CKP : i2cs_pkg::HOLD_NONE;
		end else if (is_acked) begin
			pend_r <= acked_r;
			if (was_addr_r) begin
				hold_r <= i2cs_pkg::HOLD_ADDR;
			end else begin
				hold_r <= stretch_enable_bit_i ? i2cs_pkg::HOLD_CKP : i2cs_pkg::HOLD_NONE;
			end
		end else if (pend_r && go_ok) begin
			pend_r <= 1'b0;
			go_tgl_r <= !go_tgl_r;
		end
	end

	// interrupt flag; a set beats a clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_r <= 1'b0;
		end else if ((is_start && start_irq_en_i) || (is_acked && note_r)) begin
			irq_r <= 1'b1;
		end else if (irq_clr_i) begin
			irq_r <= 1'b0;
		end
	end

	// buffer and full flag; only acknowledged bytes land
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bf_r <= 1'b0;
			buf_r <= 8'h00;
		end else if (is_byte && ack_c) begin
			bf_r <= 1'b1;
			buf_r <= ev_byte_r;
		end else if (buf_rd_i) begin
			bf_r <= 1'b0;
		end
	end

	// address update flag, cleared by an own address write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ua_r <= 1'b0;
		end else if (is_byte && ((cst_r == i2cs_pkg::C_HI && m_hi) || cst_r == i2cs_pkg::C_LO)) begin
			ua_r <= 1'b1;
		end else if (own_addr_wr_i) begin
			ua_r <= 1'b0;
		end
	end

	// own address register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			own_r <= i2cs_pkg::OWN_ADDR_RST;
		end else if (own_addr_wr_i) begin
			own_r <= own_addr_i;
		end
	end

	// clock release bit; hardware clear beats software set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ckp_r <= 1'b1;
		end else if (ckp_clr) begin
			ckp_r <= 1'b0;
		end else if (ckp_set_i) begin
			ckp_r <= 1'b1;
		end
	end

	// start seen until stop
	always_ff @(posedge clk_i) begin
		if (rst_i || is_stop) begin
			ss_r <= 1'b0;
		end else if (is_start) begin
			ss_r <= 1'b1;
		end
	end

	assign port_irq_flag_o = irq_r;
	assign buffer_full_flag_o = bf_r;
	assign address_update_flag_o = ua_r;
	assign clock_release_bit_o = ckp_r;
	assign start_seen_o = ss_r;
	assign rx_tx_buffer_o = buf_r;
	assign own_address_o = own_r;
endmodule

// [verification/i2cs_chk.sv]
/*
 * wire checker for the slave and master ends of the scl/sda link.
 * assumes plain copies of the interface signals, both clocks and the reset.
 */
`timescale 1ns/10ps
module i2cs_chk (
	input wire logic clk_i, // system clock
	input wire logic link_clk_i, // link clock
	input wire logic rst_i, // sync reset, high
	input wire logic scl_dev_o, // slave scl level
	input wire logic scl_dev_oe, // slave scl pull
	input wire logic sda_dev_o, // slave sda level
	input wire logic sda_dev_oe, // slave sda pull
	input wire logic scl_host_o, // master scl level
	input wire logic scl_host_oe, // master scl pull
	input wire logic sda_host_o, // master sda level
	input wire logic sda_host_oe, // master sda pull
	input wire logic scl, // wire scl
	input wire logic sda // wire sda
);
	// slave side, seen on the link clock
	a_dev_pull_only: assert property (@(posedge link_clk_i) disable iff (rst_i)
		!scl_dev_o && !sda_dev_o) else $error("slave drives a line high");
	a_stretch_in_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$rose(scl_dev_oe) |-> !$past(scl)) else $error("slave grabs scl while high");
	a_dev_sda_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$changed(sda_dev_oe) |-> !$past(scl)) else $error("slave moves sda while scl high");
	a_ack_released: assert property (@(posedge link_clk_i) disable iff (rst_i)
		sda_dev_oe && $fell(scl) |-> ##[1:8] !sda_dev_oe) else $error("ack not released");
	// master side, seen on the system clock
	a_host_pull_only: assert property (@(posedge clk_i) disable iff (rst_i)
		!scl_host_o && !sda_host_o) else $error("master drives a line high");
	a_host_waits_scl: assert property (@(posedge clk_i) disable iff (rst_i)
		!scl_host_oe && !scl |=> !scl_host_oe) else $error("master pulls scl while waiting");
	a_start_scl_high: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(sda) && scl |-> scl[*2]) else $error("scl not high after start");
	a_scl_high_min: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(scl) |-> scl[*3]) else $error("scl high phase cut short");
	// main scenarios
	c_stretch: cover property (@(posedge link_clk_i) disable iff (rst_i) scl_dev_oe[*8]);
	c_ack: cover property (@(posedge link_clk_i) disable iff (rst_i) $rose(sda_dev_oe));
	c_start: cover property (@(posedge clk_i) disable iff (rst_i) $fell(sda) && scl);
endmodule

// [verification/i2cs_tb_top.sv]
/*
 * self-checking bench: master end and slave end joined by the wire interface.
 * assumes the shared package, the interface and both design ends compiled first.
 */
`timescale 1ns/10ps
module i2cs_tb_top;
	localparam int Q = 4; // shortened quarter bit
	localparam logic [7:0] HI = {i2cs_pkg::HI_PREFIX, 2'h2, 1'h0}; // address 2A5, write
	localparam logic [7:0] LO = 8'hA5;
	logic clk_i = 0, link_clk = 0, rst_i = 1;
	logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wr, bv, arr, rv;
	logic [3:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdata;
	logic [1:0] bresp, rresp;
	logic str_en = 0, ahold = 0, sirq_en = 0, own_wr = 0, buf_rd = 0, irq_clr = 0, rel_set = 0;
	logic dhold = 0;
	logic [7:0] own_in = 0, rxb, own;
	logic irq, bfull, upd, rel, sseen;
	logic [8:0] mon_sh = 0, mon_fr = 0;
	int mon_n = 0, err_count = 0, checks_done = 0;

	// clocks, the link clock with its own phase
	always #12.5 clk_i = ~clk_i;
	initial begin
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	i2cs_bus_if bus ();
	i2cs_host_end #(.QTR(Q)) i2cs_host_end_i (.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .bus(bus));
	i2cs_dev_end i2cs_dev_end_i (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk),
		.bus(bus), .stretch_enable_bit_i(str_en), .address_hold_enable_i(ahold),
		.data_hold_enable_i(dhold), .start_irq_en_i(sirq_en), .own_addr_wr_i(own_wr),
		.own_addr_i(own_in), .buf_rd_i(buf_rd), .irq_clr_i(irq_clr), .ckp_set_i(rel_set),
		.port_irq_flag_o(irq), .buffer_full_flag_o(bfull), .address_update_flag_o(upd),
		.clock_release_bit_o(rel), .start_seen_o(sseen), .rx_tx_buffer_o(rxb),
		.own_address_o(own));
	i2cs_chk i2cs_chk_i (.clk_i(clk_i), .link_clk_i(link_clk), .rst_i(rst_i),
		.scl_dev_o(bus.scl_dev_o), .scl_dev_oe(bus.scl_dev_oe), .sda_dev_o(bus.sda_dev_o),
		.sda_dev_oe(bus.sda_dev_oe), .scl_host_o(bus.scl_host_o),
		.scl_host_oe(bus.scl_host_oe), .sda_host_o(bus.sda_host_o),
		.sda_host_oe(bus.sda_host_oe), .scl(bus.scl), .sda(bus.sda));

	// wire monitor: nine bits a frame, restarted by each start
	always @(posedge bus.scl) begin
		mon_sh <= {mon_sh[7:0], bus.sda};
		if (mon_n == 8) mon_fr <= {mon_sh[7:0], bus.sda};
		mon_n <= (mon_n == 8) ? 0 : mon_n + 1;
	end
	always @(negedge bus.sda) begin
		if (bus.scl === 1'b1) mon_n <= 0;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// axi write: both channels offered together, each dropped when taken
	task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ap, wp, t;
		logic [1:0] g;
		ap = 1;
		wp = 1;
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		while (ap || wp) begin
			@(negedge clk_i);
			ap = ap && (awr !== 1'b1);
			wp = wp && (wr !== 1'b1);
			@(posedge clk_i);
			awv <= ap;
			wv <= wp;
		end
		br <= 1;
		do begin
			@(negedge clk_i);
			t = bv;
			g = bresp;
			@(posedge clk_i);
		end while (t !== 1'b1);
		br <= 0;
		chk("bresp", e, g);
	endtask

	task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t;
		ara <= a;
		arv <= 1;
		do begin
			@(negedge clk_i);
			t = arr;
			@(posedge clk_i);
		end while (t !== 1'b1);
		arv <= 0;
		rr <= 1;
		do begin
			@(negedge clk_i);
			t = rv;
			d = rdata;
			r = rresp;
			@(posedge clk_i);
		end while (t !== 1'b1);
		rr <= 0;
	endtask

	task host_idle(output logic [31:0] d);
		logic [1:0] r;
		d = 32'h1;
		while (d[i2cs_pkg::ST_BUSY] !== 1'b0) axi_rd(i2cs_pkg::REG_STAT, d, r);
	endtask

	task host_op(input logic [1:0] op, input logic [7:0] b);
		logic [31:0] d;
		host_idle(d);
		axi_wr(i2cs_pkg::REG_CMD, (32'(op) << i2cs_pkg::OP_POS) | 32'(b), i2cs_pkg::RESP_OKAY);
	endtask

	// one-cycle software pulses on the slave end
	task sw(input logic w, input logic rb, input logic clr, input logic rs, input logic [7:0] a);
		own_wr <= w;
		buf_rd <= rb;
		irq_clr <= clr;
		rel_set <= rs;
		own_in <= a;
		@(posedge clk_i);
		own_wr <= 0;
		buf_rd <= 0;
		irq_clr <= 0;
		rel_set <= 0;
		repeat (2) @(posedge clk_i);
	endtask

	task wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		chk("irq", 1, irq);
	endtask

	task chk_held;
		repeat (40) @(posedge clk_i);
		chk("scl held", 1, bus.scl_dev_oe);
	endtask

	task chk_frame(input logic [7:0] b, input logic n);
		logic [31:0] d, c;
		logic [1:0] r;
		host_idle(d);
		chk("frame", {b, n}, mon_fr);
		chk("nack", n, d[i2cs_pkg::ST_NACK]);
		axi_rd(i2cs_pkg::REG_CMD, c, r);
		chk("last byte", b, c);
	endtask

	task t_reset;
		chk("release", 1, rel);
		chk("own", i2cs_pkg::OWN_ADDR_RST, own);
		chk("flags", 0, {irq, bfull, upd, sseen});
	endtask

	task t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(4'h8, d, r);
		chk("rresp", i2cs_pkg::RESP_SLVERR, r);
		chk("rdata", 0, d);
		axi_wr(i2cs_pkg::REG_STAT, 32'h0, i2cs_pkg::RESP_SLVERR);
		axi_rd(i2cs_pkg::REG_STAT, d, r);
		chk("rresp", i2cs_pkg::RESP_OKAY, r);
	endtask

	// start and matching high byte, low address loaded afterwards
	task t_addr(input logic en);
		sirq_en <= en;
		sw(1, 0, 1, 0, HI);
		chk("own", HI, own);
		host_op(i2cs_pkg::OP_START, 8'h00);
		repeat (60) @(posedge clk_i);
		chk("start irq", en, irq);
		chk("start seen", 1, sseen);
		sw(0, 0, 1, 0, 8'h00);
		host_op(i2cs_pkg::OP_BYTE, HI);
		wait_irq;
		chk("upd", 1, upd);
		chk("buf", HI, rxb);
		chk_held;
		sw(0, 1, 1, 0, 8'h00);
		chk("full", 0, bfull);
		chk("irq", 0, irq);
		sw(1, 0, 0, 0, LO);
		chk("upd", 0, upd);
		chk_frame(HI, 0);
	endtask

	task t_good;
		logic [7:0] db [2];
		db = '{8'h3C, 8'h81};
		t_addr(1);
		str_en <= 1;
		host_op(i2cs_pkg::OP_BYTE, LO);
		wait_irq;
		chk("upd", 1, upd);
		chk("buf", LO, rxb);
		chk_held;
		sw(0, 1, 1, 0, 8'h00);
		sw(1, 0, 0, 0, HI);
		chk_frame(LO, 0);
		for (int i = 0; i < 2; i++) begin
			host_op(i2cs_pkg::OP_BYTE, db[i]);
			wait_irq;
			chk("buf", db[i], rxb);
			chk("release", 0, rel);
			chk_held;
			sw(0, 1, 1, 1, 8'h00);
			chk("release", 1, rel);
			chk("full", 0, bfull);
			chk_frame(db[i], 0);
		end
		host_op(i2cs_pkg::OP_STOP, 8'h00);
		str_en <= 0;
		host_op(i2cs_pkg::OP_START, 8'h00);
		repeat (60) @(posedge clk_i);
		chk("start seen", 1, sseen);
		chk("start irq", 1, irq);
		host_op(i2cs_pkg::OP_STOP, 8'h00);
		repeat (300) @(posedge clk_i);
		chk("start seen", 0, sseen);
	endtask

	task t_miss;
		t_addr(0);
		host_op(i2cs_pkg::OP_BYTE, 8'h5A);
		wait_irq;
		chk("upd", 1, upd);
		chk("full", 0, bfull);
		chk("release", 1, rel);
		chk_frame(8'h5A, 1);
		sw(1, 0, 1, 0, HI);
		host_op(i2cs_pkg::OP_STOP, 8'h00);
	endtask

	task t_hold;
		ahold <= 1;
		dhold <= 1;
		host_op(i2cs_pkg::OP_START, 8'h00);
		host_op(i2cs_pkg::OP_BYTE, HI);
		repeat (300) @(posedge clk_i);
		chk("hold", 1, bus.scl_dev_oe);
		sw(0, 0, 0, 1, 8'h00);
		wait_irq;
		chk("upd", 1, upd);
		sw(1, 1, 1, 0, LO);
		chk_frame(HI, 0);
		host_op(i2cs_pkg::OP_BYTE, LO);
		repeat (300) @(posedge clk_i);
		chk("hold", 1, bus.scl_dev_oe);
		chk("release", 0, rel);
		sw(0, 0, 0, 1, 8'h00);
		wait_irq;
		sw(1, 1, 1, 0, HI);
		chk_frame(LO, 0);
		host_op(i2cs_pkg::OP_BYTE, 8'h66);
		repeat (300) @(posedge clk_i);
		chk("data hold", 1, bus.scl_dev_oe);
		chk("release", 0, rel);
		sw(0, 0, 0, 1, 8'h00);
		wait_irq;
		chk("buf", 8'h66, rxb);
		sw(0, 1, 1, 0, 8'h00);
		chk_frame(8'h66, 0);
		host_op(i2cs_pkg::OP_STOP, 8'h00);
		ahold <= 0;
		dhold <= 0;
	endtask

	task summarize;
		if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_reset;
		t_regs;
		t_good;
		t_miss;
		t_hold;
		summarize;
	end

	// watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge clk_i);
		err_count++;
		summarize;
	end
endmodule
